// ### sim/tb.sv
// Self-checking bench of the channel message-type engine.
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        MCLK = 1'b0, ARST_N = 1'b0, AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b1;
	logic        ARVALID = 1'b0, RREADY = 1'b1, STALL = 1'b0, FAIL = 1'b0, INFR = 1'b0;
	logic        RX_ID_VALID = 1'b0, RX_RNW = 1'b0, RX_RTR = 1'b0, RX_BYTE_VALID = 1'b0;
	logic        RX_END_OK = 1'b0, RX_END_ERR = 1'b0;
	logic [11:0] AWADDR = 12'h000, ARADDR = 12'h000, RX_ID = 12'h000;
	logic [31:0] WDATA = 32'h00000000;
	logic [3:0]  WSTRB = 4'hf;
	logic [7:0]  RX_BYTE = 8'h00;
	logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, TX_REQ, TX_RNW, TX_RTR;
	logic        TX_TAKE, TX_DONE, TX_OK, TX_INFRAME, HIT_VALID, HIT_REPLY;
	logic [1:0]  BRESP, RRESP;
	logic [31:0] RDATA;
	logic [3:0]  TX_CHAN, HIT_CHAN;
	logic [11:0] TX_ID;
	logic [4:0]  TX_LEN, TX_RD_IDX;
	logic [7:0]  TX_RD_DATA, N_TAKE;
	int          miscompares = 0, n_tests = 0, cyc = 0;

	vme_engine vme_engine_i (.MCLK(MCLK), .ARST_N(ARST_N), .AWVALID(AWVALID),
		.AWREADY(AWREADY), .AWADDR(AWADDR), .WVALID(WVALID), .WREADY(WREADY),
		.WDATA(WDATA), .WSTRB(WSTRB), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
		.ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID),
		.RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP), .TX_REQ(TX_REQ), .TX_CHAN(TX_CHAN),
		.TX_ID(TX_ID), .TX_RNW(TX_RNW), .TX_RTR(TX_RTR), .TX_LEN(TX_LEN), .TX_TAKE(TX_TAKE),
		.TX_DONE(TX_DONE), .TX_OK(TX_OK), .TX_INFRAME(TX_INFRAME), .TX_RD_IDX(TX_RD_IDX),
		.TX_RD_DATA(TX_RD_DATA), .RX_ID_VALID(RX_ID_VALID), .RX_ID(RX_ID), .RX_RNW(RX_RNW),
		.RX_RTR(RX_RTR), .RX_BYTE_VALID(RX_BYTE_VALID), .RX_BYTE(RX_BYTE),
		.RX_END_OK(RX_END_OK), .RX_END_ERR(RX_END_ERR), .HIT_VALID(HIT_VALID),
		.HIT_CHAN(HIT_CHAN), .HIT_REPLY(HIT_REPLY));
	vme_peer vme_peer_i (.MCLK(MCLK), .ARST_N(ARST_N), .STALL(STALL), .FAIL(FAIL),
		.INFR(INFR), .TX_REQ(TX_REQ), .TX_TAKE(TX_TAKE), .TX_DONE(TX_DONE), .TX_OK(TX_OK),
		.TX_INFRAME(TX_INFRAME), .TX_RD_IDX(TX_RD_IDX), .N_TAKE(N_TAKE));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] s, e);
		n_tests++;
		if (s !== e) begin
			miscompares++;
			$display("Error at %0t: got %h, want %h", $time, s, e);
		end
	endtask : chk

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		do @(posedge MCLK); while (AWREADY !== 1'b1);
		AWVALID <= 1'b0;
		WVALID <= 1'b0;
		do @(posedge MCLK); while (BVALID !== 1'b1);
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		ARADDR <= a;
		ARVALID <= 1'b1;
		do @(posedge MCLK); while (ARREADY !== 1'b1);
		ARVALID <= 1'b0;
		do @(posedge MCLK); while (RVALID !== 1'b1);
		d = RDATA;
		r = RRESP;
	endtask : rd

	task automatic fl(input logic [3:0] c, input logic [2:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd({4'h0, c, 4'h8}, d, r);
		chk(d[2:0], e);
	endtask : fl

	// channels are armed only while no foreign frame can race them.
	task automatic arm(input logic [3:0] c, input logic [11:0] id, m, input logic [4:0] b,
		input logic [6:0] p);
		wr({4'h0, c, 4'h0}, {20'h0, id});
		wr({4'h0, c, 4'h4}, {20'h0, m});
		wr({4'h0, c, 4'h8}, {11'h0, 5'h03, 1'b0, p, 3'h0, b});
	endtask : arm

	task automatic tk(input logic [3:0] c, input logic [1:0] k, input logic [11:0] i);
		do @(posedge MCLK); while ((TX_TAKE & TX_REQ) !== 1'b1);
		chk(TX_CHAN, c);
		chk({TX_RNW, TX_RTR}, k);
		chk(TX_ID, i);
		chk(TX_LEN, 5'h02);
		do @(posedge MCLK); while (TX_DONE !== 1'b1);
		repeat (2) @(posedge MCLK);
	endtask : tk

	task automatic rx(input logic [11:0] id, input logic w, t, input int n, input logic h,
		input logic [3:0] c, input logic p);
		RX_ID_VALID <= 1'b1;
		RX_ID <= id;
		RX_RNW <= w;
		RX_RTR <= t;
		@(posedge MCLK);
		RX_ID_VALID <= 1'b0;
		RX_ID <= ~id;
		@(posedge MCLK);
		chk(HIT_VALID, h);
		if (h) begin
			chk(HIT_CHAN, c);
			chk(HIT_REPLY, p);
		end
		for (int i = 0; i < n; i++) begin
			RX_BYTE_VALID <= 1'b1;
			RX_BYTE <= 8'ha0 + 8'(i);
			@(posedge MCLK);
		end
		RX_BYTE_VALID <= 1'b0;
		RX_END_OK <= 1'b1;
		@(posedge MCLK);
		RX_END_OK <= 1'b0;
		repeat (2) @(posedge MCLK);
	endtask : rx

	task automatic complete_run();
		if (miscompares == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : complete_run

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0]  r;
		fl(4'h0, 3'b011);
		rd(12'h0f0, d, r);
		chk(r, vme_pkg::RESP_SLV);
		chk(N_TAKE, 8'h00);
	endtask : t_reset

	// The stalled channel 5 keeps the arbiter busy so that channels 2 and 1 wait together.
	task automatic t_tx();
		STALL <= 1'b1;
		arm(4'h5, 12'h050, 12'hfff, 5'b00000, 7'h30);
		arm(4'h2, 12'h020, 12'hfff, 5'b00000, 7'h34);
		arm(4'h1, 12'h010, 12'hfff, 5'b00001, 7'h38);
		STALL <= 1'b0;
		tk(4'h1, 2'h0, 12'h010);
		tk(4'h2, 2'h0, 12'h020);
		fl(4'h1, 3'b011);
		fl(4'h2, 3'b010);
		FAIL <= 1'b1;
		arm(4'h6, 12'h060, 12'hfff, 5'b00000, 7'h3c);
		tk(4'h6, 2'h0, 12'h060);
		tk(4'h6, 2'h0, 12'h060);
		FAIL <= 1'b0;
		fl(4'h6, 3'b110);
	endtask : t_tx

	task automatic t_rx();
		logic [31:0] d;
		logic [1:0]  r;
		logic [7:0]  n;
		n = N_TAKE;
		arm(4'h3, 12'h120, 12'hff0, 5'b01000, 7'h08);
		arm(4'h7, 12'h120, 12'hff0, 5'b01000, 7'h10);
		rx(12'h13a, 1'b0, 1'b0, 0, 1'b0, 4'h0, 1'b0);
		rx(12'h12a, 1'b0, 1'b0, 2, 1'b1, 4'h3, 1'b0);
		fl(4'h3, 3'b001);
		rd(12'h030, d, r);
		chk(d[11:0], 12'h12a);
		for (int i = 0; i < 3; i++) begin
			rd(12'h220 + 12'(4 * i), d, r);
			chk(d[7:0], (i == 0) ? 8'h02 : 8'h9f + 8'(i));
		end
		rx(12'h12a, 1'b0, 1'b0, 2, 1'b1, 4'h7, 1'b0);
		rx(12'h125, 1'b0, 1'b0, 0, 1'b0, 4'h0, 1'b0);
		chk(N_TAKE, n);
	endtask : t_rx

	task automatic t_reply();
		arm(4'h8, 12'h300, 12'hfff, 5'b11000, 7'h18);
		tk(4'h8, 2'h3, 12'h300);
		fl(4'h8, 3'b010);
		rx(12'h300, 1'b1, 1'b0, 0, 1'b1, 4'h8, 1'b0);
		fl(4'h8, 3'b011);
		INFR <= 1'b1;
		arm(4'h9, 12'h301, 12'hfff, 5'b11000, 7'h1c);
		tk(4'h9, 2'h3, 12'h301);
		INFR <= 1'b0;
		fl(4'h9, 3'b011);
		arm(4'ha, 12'h400, 12'hfff, 5'b10000, 7'h20);
		rx(12'h400, 1'b1, 1'b1, 0, 1'b1, 4'ha, 1'b1);
		fl(4'ha, 3'b011);
		arm(4'hb, 12'h401, 12'hfff, 5'b10010, 7'h24);
		rx(12'h401, 1'b1, 1'b1, 0, 1'b1, 4'hb, 1'b0);
		fl(4'hb, 3'b011);
		wr(12'h2a4, 32'h0000005a);
		arm(4'hc, 12'h402, 12'hfff, 5'b10001, 7'h28);
		tk(4'hc, 2'h2, 12'h402);
		chk(TX_RD_DATA, 8'h5a);
		fl(4'hc, 3'b011);
		arm(4'hd, 12'h403, 12'hfff, 5'b11001, 7'h2c);
		tk(4'hd, 2'h3, 12'h403);
		rx(12'h403, 1'b1, 1'b0, 0, 1'b0, 4'h0, 1'b0);
	endtask : t_reply

	always #2.5 MCLK = ~MCLK;

	always @(posedge MCLK) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			complete_run();
		end
	end

	initial begin
		repeat (2) @(posedge MCLK);
		ARST_N <= 1'b1;
		t_reset();
		t_tx();
		t_rx();
		t_reply();
		complete_run();
	end
endmodule : tb

// ### sim/vme_peer.sv
// Frame-layer model that takes transmit offers and reports their outcome.
module vme_peer (
	// Clock and reset
	input  wire logic       MCLK,
	input  wire logic       ARST_N,
	// Bench controls
	input  wire logic       STALL,
	input  wire logic       FAIL,
	input  wire logic       INFR,
	// Transmit link
	input  wire logic       TX_REQ,
	output logic            TX_TAKE,
	output logic            TX_DONE,
	output logic            TX_OK,
	output logic            TX_INFRAME,
	output logic [4:0]      TX_RD_IDX,
	output logic [7:0]      N_TAKE
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [2:0] wait_reg;

	// attempt outcome.
	// Outcome lines carry the inverse outside the done pulse, so a design sampling late fails.
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			TX_TAKE <= 1'b0;
			TX_DONE <= 1'b0;
			TX_OK <= 1'b0;
			TX_INFRAME <= 1'b0;
			TX_RD_IDX <= 5'h00;
			N_TAKE <= 8'h00;
			wait_reg <= 3'h0;
		end else begin
			TX_TAKE <= 1'b0;
			TX_DONE <= 1'b0;
			TX_OK <= FAIL;
			TX_INFRAME <= !INFR;
			TX_RD_IDX <= (wait_reg != 3'h0) ? TX_RD_IDX + 5'h01 : 5'h00;
			if (TX_REQ && !TX_TAKE && wait_reg == 3'h0) begin
				TX_TAKE <= 1'b1;
				N_TAKE <= N_TAKE + 8'h01;
				wait_reg <= 3'h4;
			end else if (wait_reg == 3'h1 && !STALL) begin
				TX_DONE <= 1'b1;
				TX_OK <= !FAIL;
				TX_INFRAME <= INFR;
				wait_reg <= 3'h0;
			end else if (wait_reg != 3'h0 && !STALL) begin
				wait_reg <= wait_reg - 3'h1;
			end
		end
	end
endmodule : vme_peer

// ### src/vme_engine.sv
// Channel message-type engine with its AXI4-Lite register slave.
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
module vme_engine #(
	parameter int NCH  = 14,
	parameter int RAMD = 128
) (
	// Clock and reset
	input  wire logic        MCLK,
	input  wire logic        ARST_N,
	// AXI4-Lite slave
	input  wire logic        AWVALID,
	output logic             AWREADY,
	input  wire logic [11:0] AWADDR,
	input  wire logic        WVALID,
	output logic             WREADY,
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	output logic             BVALID,
	input  wire logic        BREADY,
	output logic [1:0]       BRESP,
	input  wire logic        ARVALID,
	output logic             ARREADY,
	input  wire logic [11:0] ARADDR,
	output logic             RVALID,
	input  wire logic        RREADY,
	output logic [31:0]      RDATA,
	output logic [1:0]       RRESP,
	// Frame layer, transmit side
	output logic             TX_REQ,
	output logic [3:0]       TX_CHAN,
	output logic [11:0]      TX_ID,
	output logic             TX_RNW,
	output logic             TX_RTR,
	output logic [4:0]       TX_LEN,
	input  wire logic        TX_TAKE,
	input  wire logic        TX_DONE,
	input  wire logic        TX_OK,
	input  wire logic        TX_INFRAME,
	input  wire logic [4:0]  TX_RD_IDX,
	output logic [7:0]       TX_RD_DATA,
	// Frame layer, receive side
	input  wire logic        RX_ID_VALID,
	input  wire logic [11:0] RX_ID,
	input  wire logic        RX_RNW,
	input  wire logic        RX_RTR,
	input  wire logic        RX_BYTE_VALID,
	input  wire logic [7:0]  RX_BYTE,
	input  wire logic        RX_END_OK,
	input  wire logic        RX_END_ERR,
	output logic             HIT_VALID,
	output logic [3:0]       HIT_CHAN,
	output logic             HIT_REPLY
);
	localparam int CW = 4;
	localparam int AW = $clog2(RAMD);

	logic [11:0]          id_reg [NCH];
	logic [11:0]          mask_reg [NCH];
	logic [AW-1:0]        ptr_reg [NCH];
	logic [4:0]           len_reg [NCH];
	logic [NCH-1:0]       dir_reg, rtr_reg, sent_reg, got_reg, err_reg;
	logic [3:0]           retry_reg, tries_reg;
	logic                 tries_ok_reg;
	logic [7:0]           ram [RAMD];
	vme_pkg::vme_tx_type  tx_reg;
	logic [CW-1:0]        txc_reg;
	vme_pkg::vme_rk_type  rk_reg;
	logic                 rx_act_reg, rx_own_reg;
	logic [CW-1:0]        rxc_reg;
	logic [4:0]           cnt_reg;
	logic [11:0]          rid_reg;
	logic                 rrnw_reg, rrtr_reg;
	logic [NCH-1:0]       rdy_vec, hit_vec, set_sent, set_got, set_err;
	logic                 wr_go, rd_go, tx_end, exceed, rx_fin, len_we;
	logic                 byte_we, ram_rx_we;
	logic [AW-1:0]        ram_rx_a;
	logic [7:0]           ram_rx_d;
	logic [CW-1:0]        rdc;
	logic [31:0]          rd_word;
	logic [31:0]          cw_new [NCH];

	// ----------------------------------------------------------------
	// Decoding functions
	// ----------------------------------------------------------------
	function automatic logic tx_ready(input logic d, r, s, g);
		// R6: reply request sent
		// R12: deferred reply sent
		return (!d && !r && !s) || (d && r && !s) || (d && !r && !s && g);
	endfunction : tx_ready

	function automatic vme_pkg::vme_rk_type rx_kind(input logic d, r, s, g, frtr);
		// R17: inactive drops out
		if (s && g)
			return vme_pkg::RK_NONE;
		// R3: plain receive listens
		else if (!d && r && !g && !frtr)
			return vme_pkg::RK_DATA;
		// R7: listen after request
		// R9: reply sets got
		else if (d && r && s && !frtr)
			return vme_pkg::RK_DATA;
		// R13: request detector listens
		else if (d && !r && s && frtr)
			return vme_pkg::RK_DETECT;
		else if (d && !r && !s && !g && frtr)
			return vme_pkg::RK_REPLY;
		return vme_pkg::RK_NONE;
	endfunction : rx_kind

	function automatic logic [CW-1:0] lowest(input logic [NCH-1:0] v);
		lowest = '0;
		for (int i = NCH - 1; i >= 0; i--)
			if (v[i])
				lowest = CW'(i);
	endfunction : lowest

	function automatic logic [31:0] ctrl_word(input int c);
		ctrl_word = '0;
		ctrl_word[vme_pkg::CTRL_GOT]  = got_reg[c];
		ctrl_word[vme_pkg::CTRL_SENT] = sent_reg[c];
		ctrl_word[vme_pkg::CTRL_ERR]  = err_reg[c];
		ctrl_word[vme_pkg::CTRL_RTR]  = rtr_reg[c];
		ctrl_word[vme_pkg::CTRL_DIR]  = dir_reg[c];
		ctrl_word[vme_pkg::CTRL_PTR +: AW] = ptr_reg[c];
		ctrl_word[vme_pkg::CTRL_LEN +: 5]  = len_reg[c];
	endfunction : ctrl_word

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
			input logic [3:0] s);
		for (int b = 0; b < 4; b++)
			if (s[b])
				o[8*b +: 8] = n[8*b +: 8];
		return o;
	endfunction : merge

	function automatic logic is_chan(input logic [11:0] a, input int c);
		return a[11:8] == 4'h0 && a[7:4] == CW'(c);
	endfunction : is_chan

	function automatic logic is_ram(input logic [11:0] a);
		return a[11:9] == vme_pkg::RAM_BASE[11:9] && int'(a[8:2]) < RAMD;
	endfunction : is_ram

	// ----------------------------------------------------------------
	// Matching and arbitration
	// ----------------------------------------------------------------
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			// R14: inactive never ready
			rdy_vec[c] = tx_ready(dir_reg[c], rtr_reg[c], sent_reg[c], got_reg[c]);
			// R20: masked identifier compare
			hit_vec[c] = ((RX_ID ^ id_reg[c]) & mask_reg[c]) == 12'h000 &&
				rx_kind(dir_reg[c], rtr_reg[c], sent_reg[c], got_reg[c], RX_RTR)
				!= vme_pkg::RK_NONE;
			cw_new[c]  = merge(ctrl_word(c), WDATA, WSTRB);
		end
	end

	assign tx_end    = tx_reg == vme_pkg::TX_BUSY && TX_DONE;
	assign exceed    = tx_end && !TX_OK && tries_reg == 4'h0;
	assign rx_fin    = RX_END_OK && rx_act_reg && !rx_own_reg;
	assign len_we    = rx_act_reg && rk_reg == vme_pkg::RK_DATA &&
		(rx_fin || (tx_end && rx_own_reg && TX_OK && TX_INFRAME));
	assign byte_we   = rx_act_reg && rk_reg == vme_pkg::RK_DATA && RX_BYTE_VALID &&
		6'(cnt_reg) + 6'h01 < 6'(len_reg[rxc_reg]);
	assign ram_rx_we = len_we || byte_we;
	assign ram_rx_a  = len_we ? ptr_reg[rxc_reg] : AW'(ptr_reg[rxc_reg] + AW'(cnt_reg) + 1'b1);
	assign ram_rx_d  = len_we ? {1'b0, rrnw_reg, rrtr_reg, cnt_reg} : RX_BYTE;

	// Flags are set by clean ends or by running out of retries; err is also set by a reception ending in error.
	always_comb begin
		set_sent = '0;
		set_got  = '0;
		set_err  = '0;
		if (tx_end) begin
			// R1: sent after transmit
			if (TX_OK || exceed)
				set_sent[txc_reg] = 1'b1;
			if (exceed)
				set_err[txc_reg] = 1'b1;
			// R8: both flags together
			if (TX_OK && TX_INFRAME && dir_reg[txc_reg] && rtr_reg[txc_reg] &&
					!got_reg[txc_reg])
				set_got[txc_reg] = 1'b1;
		end
		// R19: clean reception only
		if (rx_fin) begin
			set_got[rxc_reg] = 1'b1;
			// R11: immediate reply both
			if (rk_reg == vme_pkg::RK_REPLY)
				set_sent[rxc_reg] = 1'b1;
		end
		if (RX_END_ERR && rx_act_reg)
			set_err[rxc_reg] = 1'b1;
	end

	// ----------------------------------------------------------------
	// Transmit arbiter
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			tx_reg       <= vme_pkg::TX_IDLE;
			txc_reg      <= '0;
			tries_reg    <= '0;
			tries_ok_reg <= 1'b0;
			TX_ID        <= '0;
			TX_RNW       <= 1'b0;
			TX_RTR       <= 1'b0;
			TX_LEN       <= '0;
		end else begin
			unique case (tx_reg)
				vme_pkg::TX_IDLE: begin
					// R18: lowest ready wins
					if (|rdy_vec) begin
						tx_reg  <= vme_pkg::TX_OFFER;
						txc_reg <= lowest(rdy_vec);
						TX_ID   <= id_reg[lowest(rdy_vec)];
						TX_RNW  <= dir_reg[lowest(rdy_vec)];
						TX_RTR  <= rtr_reg[lowest(rdy_vec)];
						TX_LEN  <= len_reg[lowest(rdy_vec)] - 5'h01;
						if (txc_reg != lowest(rdy_vec))
							tries_ok_reg <= 1'b0;
					end
				end
				vme_pkg::TX_OFFER: begin
					if (!rdy_vec[txc_reg])
						tx_reg <= vme_pkg::TX_IDLE;
					else if (TX_TAKE) begin
						tx_reg <= vme_pkg::TX_BUSY;
						if (!tries_ok_reg) begin
							tries_reg    <= retry_reg;
							tries_ok_reg <= 1'b1;
						end
					end
				end
				vme_pkg::TX_BUSY: begin
					// R21: rearbitrate after attempt
					if (TX_DONE) begin
						tx_reg <= vme_pkg::TX_IDLE;
						// R2: repeat until exceeded
						if (TX_OK || exceed)
							tries_ok_reg <= 1'b0;
						else
							tries_reg <= tries_reg - 4'h1;
					end
				end
			endcase
		end
	end

	assign TX_REQ  = tx_reg == vme_pkg::TX_OFFER;
	assign TX_CHAN = txc_reg;

	// ----------------------------------------------------------------
	// Receive tracking
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rx_act_reg <= 1'b0;
			rx_own_reg <= 1'b0;
			rk_reg     <= vme_pkg::RK_NONE;
			rxc_reg    <= '0;
			cnt_reg    <= '0;
			rid_reg    <= '0;
			rrnw_reg   <= 1'b0;
			rrtr_reg   <= 1'b0;
			HIT_VALID  <= 1'b0;
			HIT_CHAN   <= '0;
			HIT_REPLY  <= 1'b0;
		end else begin
			HIT_VALID <= 1'b0;
			if (RX_ID_VALID && |hit_vec) begin
				// R16: lowest match receives
				rx_act_reg <= 1'b1;
				rx_own_reg <= 1'b0;
				rxc_reg    <= lowest(hit_vec);
				rk_reg     <= rx_kind(dir_reg[lowest(hit_vec)], rtr_reg[lowest(hit_vec)],
					sent_reg[lowest(hit_vec)], got_reg[lowest(hit_vec)], RX_RTR);
				cnt_reg    <= '0;
				rid_reg    <= RX_ID;
				rrnw_reg   <= RX_RNW;
				rrtr_reg   <= RX_RTR;
				HIT_VALID  <= 1'b1;
				HIT_CHAN   <= lowest(hit_vec);
				HIT_REPLY  <= rx_kind(dir_reg[lowest(hit_vec)], rtr_reg[lowest(hit_vec)],
					sent_reg[lowest(hit_vec)], got_reg[lowest(hit_vec)], RX_RTR)
					== vme_pkg::RK_REPLY;
			// R15: occupied buffer takes nothing
			end else if (tx_reg == vme_pkg::TX_OFFER && TX_TAKE && TX_RNW && TX_RTR &&
					!got_reg[txc_reg]) begin
				rx_act_reg <= 1'b1;
				rx_own_reg <= 1'b1;
				rxc_reg    <= txc_reg;
				rk_reg     <= vme_pkg::RK_DATA;
				cnt_reg    <= '0;
				rid_reg    <= TX_ID;
				rrnw_reg   <= 1'b1;
				rrtr_reg   <= 1'b1;
			end else begin
				if (RX_BYTE_VALID && rx_act_reg && cnt_reg != 5'h1f)
					cnt_reg <= cnt_reg + 5'h01;
				if (rx_fin || (RX_END_ERR && rx_act_reg) || (tx_end && rx_own_reg))
					rx_act_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Channel registers
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			for (int c = 0; c < NCH; c++) begin
				id_reg[c]   <= vme_pkg::RST_ID;
				mask_reg[c] <= vme_pkg::RST_MASK;
				ptr_reg[c]  <= '0;
				len_reg[c]  <= '0;
			end
			dir_reg   <= '0;
			rtr_reg   <= '0;
			sent_reg  <= {NCH{1'b1}};
			got_reg   <= {NCH{1'b1}};
			err_reg   <= '0;
			retry_reg <= vme_pkg::RST_RETRY;
		end else begin
			for (int c = 0; c < NCH; c++) begin
				if (wr_go && is_chan(AWADDR, c) && AWADDR[3:0] == vme_pkg::OFS_ID[3:0])
					id_reg[c] <= 12'(merge(32'(id_reg[c]), WDATA, WSTRB));
				// R5: received identifier kept
				else if (rx_fin && rxc_reg == CW'(c))
					id_reg[c] <= rid_reg;
				if (wr_go && is_chan(AWADDR, c) && AWADDR[3:0] == vme_pkg::OFS_MASK[3:0])
					mask_reg[c] <= 12'(merge(32'(mask_reg[c]), WDATA, WSTRB));
				// R19: hardware set beats clear
				if (wr_go && is_chan(AWADDR, c) && AWADDR[3:0] == vme_pkg::OFS_CTRL[3:0]) begin
					dir_reg[c]  <= cw_new[c][vme_pkg::CTRL_DIR];
					rtr_reg[c]  <= cw_new[c][vme_pkg::CTRL_RTR];
					ptr_reg[c]  <= cw_new[c][vme_pkg::CTRL_PTR +: AW];
					len_reg[c]  <= cw_new[c][vme_pkg::CTRL_LEN +: 5];
					got_reg[c]  <= cw_new[c][vme_pkg::CTRL_GOT] | set_got[c];
					sent_reg[c] <= cw_new[c][vme_pkg::CTRL_SENT] | set_sent[c];
					err_reg[c]  <= cw_new[c][vme_pkg::CTRL_ERR] | set_err[c];
				end else begin
					got_reg[c]  <= got_reg[c] | set_got[c];
					sent_reg[c] <= sent_reg[c] | set_sent[c];
					err_reg[c]  <= err_reg[c] | set_err[c];
				end
			end
			if (wr_go && AWADDR == vme_pkg::OFS_RETRY && WSTRB[0])
				retry_reg <= WDATA[3:0];
		end
	end

	// ----------------------------------------------------------------
	// Message buffer
	// ----------------------------------------------------------------
	assign rdc = (rx_act_reg && rk_reg == vme_pkg::RK_REPLY) ? rxc_reg : txc_reg;

	always_ff @(posedge MCLK) begin
		// R4: data and length stored
		if (ram_rx_we)
			ram[ram_rx_a] <= ram_rx_d;
		else if (wr_go && is_ram(AWADDR) && WSTRB[0])
			ram[AWADDR[AW+1:2]] <= WDATA[7:0];
	end

	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N)
			TX_RD_DATA <= '0;
		else
			TX_RD_DATA <= ram[AW'(ptr_reg[rdc] + AW'(TX_RD_IDX) + 1'b1)];
	end

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	// Bus writes wait while the receiver owns the buffer write port.
	assign wr_go   = AWVALID && WVALID && !BVALID && !ram_rx_we;
	assign AWREADY = wr_go;
	assign WREADY  = wr_go;
	assign rd_go   = ARVALID && !RVALID;
	assign ARREADY = !RVALID;

	always_comb begin
		rd_word = '0;
		for (int c = 0; c < NCH; c++)
			if (is_chan(ARADDR, c))
				rd_word = ARADDR[3:0] == vme_pkg::OFS_ID[3:0]   ? 32'(id_reg[c]) :
				          ARADDR[3:0] == vme_pkg::OFS_MASK[3:0] ? 32'(mask_reg[c]) :
				          ARADDR[3:0] == vme_pkg::OFS_CTRL[3:0] ? ctrl_word(c) : 32'h0;
		if (ARADDR == vme_pkg::OFS_RETRY)
			rd_word = 32'(retry_reg);
		if (ARADDR == vme_pkg::OFS_STATUS) begin
			rd_word[CW-1:0]                  = txc_reg;
			rd_word[vme_pkg::STAT_BUSY]      = tx_reg != vme_pkg::TX_IDLE;
			rd_word[vme_pkg::STAT_TRY +: 4]  = tries_reg;
		end
		if (is_ram(ARADDR))
			rd_word = 32'(ram[ARADDR[AW+1:2]]);
	end

	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			BVALID <= 1'b0;
			BRESP  <= vme_pkg::RESP_OKAY;
			RVALID <= 1'b0;
			RDATA  <= '0;
			RRESP  <= vme_pkg::RESP_OKAY;
		end else begin
			if (wr_go) begin
				BVALID <= 1'b1;
				BRESP  <= (AWADDR[11:8] == 4'h0 && AWADDR[7:4] < CW'(NCH) &&
					AWADDR[3:0] <= vme_pkg::OFS_CTRL[3:0]) || is_ram(AWADDR) ||
					AWADDR == vme_pkg::OFS_RETRY || AWADDR == vme_pkg::OFS_STATUS ?
					vme_pkg::RESP_OKAY : vme_pkg::RESP_SLV;
			end else if (BREADY)
				BVALID <= 1'b0;
			if (rd_go) begin
				RVALID <= 1'b1;
				RDATA  <= rd_word;
				RRESP  <= (ARADDR[11:8] == 4'h0 && ARADDR[7:4] < CW'(NCH) &&
					ARADDR[3:0] <= vme_pkg::OFS_CTRL[3:0]) || is_ram(ARADDR) ||
					ARADDR == vme_pkg::OFS_RETRY || ARADDR == vme_pkg::OFS_STATUS ?
					vme_pkg::RESP_OKAY : vme_pkg::RESP_SLV;
			end else if (RREADY)
				RVALID <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking @(posedge MCLK); endclocking
	default disable iff (!ARST_N);

	AST_TX_LOWEST: assert property (TX_REQ && !$past(TX_REQ) |-> // R18
		($past(rdy_vec) & ((NCH)'(1) << txc_reg) - (NCH)'(1)) == '0)
		else $error("Offered channel is not the lowest ready one.");
	AST_TX_INACTIVE: assert property (TX_REQ |-> // R14
		!(sent_reg[txc_reg] && got_reg[txc_reg]) && rdy_vec[txc_reg] ##1 1'b1)
		else $error("Inactive channel offered for transmission.");
	AST_RX_LOWEST: assert property (RX_ID_VALID && |hit_vec |=> // R16
		HIT_VALID && HIT_CHAN == lowest($past(hit_vec)) && rx_act_reg)
		else $error("Frame not given to the lowest matching channel.");
	AST_SENT_OK: assert property (tx_end && TX_OK && !TX_RNW |=> // R1
		sent_reg[txc_reg] && tx_reg == vme_pkg::TX_IDLE)
		else $error("Transmit channel did not set its sent flag.");
	AST_INFRAME: assert property (tx_end && TX_OK && TX_INFRAME && TX_RNW && TX_RTR &&
		!got_reg[txc_reg] |=> sent_reg[txc_reg] && got_reg[txc_reg]) // R8
		else $error("In-frame answer did not set both flags.");
	AST_EXCEED: assert property (exceed |=> sent_reg[txc_reg] && err_reg[txc_reg] && // R2
		!tries_ok_reg)
		else $error("Retry exhaustion did not close the channel.");
	AST_RX_GOT: assert property (rx_fin && rk_reg == vme_pkg::RK_DATA |=> // R3
		got_reg[$past(rxc_reg)] && id_reg[$past(rxc_reg)] == $past(rid_reg) && !rx_act_reg)
		else $error("Reception did not set got or keep the identifier.");
	AST_LEN_BYTE: assert property (len_we |=> // R4
		ram[$past(ptr_reg[rxc_reg])][4:0] == $past(cnt_reg))
		else $error("Length byte not written to buffer head.");
	AST_NO_RX_TX: assert property (TX_REQ |-> !(!TX_RNW && TX_RTR)) // R3
		else $error("Receive channel offered a frame.");
	AST_DETECT: assert property (rx_fin && rk_reg == vme_pkg::RK_DETECT |=> // R13
		got_reg[$past(rxc_reg)] && !HIT_REPLY)
		else $error("Detector channel mishandled a reply request.");

	CVR_TX_DONE: cover property (tx_end && TX_OK);
	CVR_RETRY: cover property (tx_end && !TX_OK ##[1:50] tx_end && TX_OK);
	CVR_RX_DATA: cover property (rx_fin && rk_reg == vme_pkg::RK_DATA);
	CVR_REPLY: cover property (HIT_VALID && HIT_REPLY);

endmodule : vme_engine

// ### src/vme_pkg.sv
// Constants and types of the channel message-type engine.
// Summary of operation
// R1: Transmit type sends frame, then sets sent.
// R2: Transmit repeats until success or retries exceeded.
// R3: Receive type listens, stores match, sets got.
// R4: Received bytes stored, length in first byte.
// R5: Received identifier written back to channel.
// R6: Reply request type sends reply request frame.
// R7: No in-frame answer: set sent, await reply.
// R8: In-frame answer sets both flags at once.
// R9: Waiting reply channel listens, then sets got.
// R10: Software avoids arming requests that may race.
// R11: Immediate reply answers in-frame, sets both flags.
// R12: Deferred reply transmits at once, sets sent.
// R13: Detector takes reply request, sets got only.
// R14: Both flags set means channel is inactive.
// R15: Illegal request transmits but ignores the reply.
// R16: Lowest matching channel takes the received frame.
// R17: Inactive channels drop out of later matching.
// R18: Lowest ready channel wins transmit arbitration.
// R19: Device sets flags only on clean ends; here retry exhaustion sets sent and err, a reception ending in error sets err.
// R20: Mask bit one compares, zero ignores bit.
// R21: Arbiter rechecks readiness after every attempt.
package vme_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_ID     = 12'h000;
	localparam logic [11:0] OFS_MASK   = 12'h004;
	localparam logic [11:0] OFS_CTRL   = 12'h008;
	localparam logic [11:0] OFS_RETRY  = 12'h100;
	localparam logic [11:0] OFS_STATUS = 12'h104;
	localparam logic [11:0] RAM_BASE   = 12'h200;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_GOT  = 0;
	localparam int CTRL_SENT = 1;
	localparam int CTRL_ERR  = 2;
	localparam int CTRL_RTR  = 3;
	localparam int CTRL_DIR  = 4;
	localparam int CTRL_PTR  = 8;
	localparam int CTRL_LEN  = 16;
	localparam int STAT_BUSY = 8;
	localparam int STAT_TRY  = 12;

	// ----------------------------------------------------------------
	// Reset values and answers
	// ----------------------------------------------------------------
	localparam logic [11:0] RST_ID    = 12'h000;
	localparam logic [11:0] RST_MASK  = 12'hfff;
	localparam logic [3:0]  RST_RETRY = 4'h1;
	localparam logic [1:0]  RESP_OKAY = 2'h0;
	localparam logic [1:0]  RESP_SLV  = 2'h2;

	typedef enum logic [1:0] {TX_IDLE, TX_OFFER, TX_BUSY} vme_tx_type;
	typedef enum logic [1:0] {RK_NONE, RK_DATA, RK_DETECT, RK_REPLY} vme_rk_type;

endpackage : vme_pkg
